/* File: rtl/cis_regs.svh */
`ifndef CIS_REGS_SVH
`define CIS_REGS_SVH
// register port byte offsets
`define CIS_OFS_WORK 8'h00
`define CIS_OFS_BANK 8'h04
`define CIS_OFS_STATUS 8'h08
`define CIS_OFS_TPTR 8'h0c
`define CIS_OFS_TBLLAT 8'h10
`define CIS_OFS_CTRL 8'h14
`define CIS_OFS_IDXBASE 8'h18
`define CIS_OFS_DADDR 8'h1c
`define CIS_OFS_DDATA 8'h20
// status flag positions
`define CIS_ST_C 0
`define CIS_ST_DC 1
`define CIS_ST_Z 2
`define CIS_ST_OV 3
`define CIS_ST_N 4
// control bit positions
`define CIS_CTRL_EXT 0
`define CIS_CTRL_BUSY 1
// opcode patterns
`define CIS_OP6_SUBB 6'h16
`define CIS_OP6_SWAP 6'h0e
`define CIS_OP6_XORF 6'h06
`define CIS_OP7_TSTZ 7'h33
`define CIS_OP8_XORL 8'h0a
`define CIS_OP14_TRD 14'h0002
`define CIS_OP14_TWR 14'h0003
// operand addressing
`define CIS_ACC_SPLIT 8'h80
`define CIS_IDX_MAX 8'h5f
`define CIS_ACC_HI_BANK 4'hf
// quarter phases
`define CIS_Q1 2'h0
`define CIS_Q2 2'h1
`define CIS_Q3 2'h2
`define CIS_Q4 2'h3
// table pointer update modes
`define CIS_TBL_KEEP 2'h0
`define CIS_TBL_POSTINC 2'h1
`define CIS_TBL_POSTDEC 2'h2
`define CIS_TBL_PREINC 2'h3
// extra instruction cycles
`define CIS_XTRA_TBL 2'h1
`define CIS_XTRA_SKIP1 2'h1
`define CIS_XTRA_SKIP2 2'h2
// reset values
`define CIS_RST_WORK 8'h00
`define CIS_RST_BANK 4'h0
`define CIS_RST_STATUS 5'h00
`define CIS_RST_TPTR 21'h000000
`define CIS_RST_TBLLAT 8'h00
`define CIS_RST_IDXBASE 12'h000
`define CIS_RST_IR 16'h0000
`endif

/* File: rtl/cis_pkg.sv */
package cis_pkg;
  typedef enum logic [1:0] {
    CIS_S_IDLE = 2'b01,
    CIS_S_RUN = 2'b10
  } cis_state_t;

  typedef enum logic [7:0] {
    CIS_OP_NONE = 8'b00000001,
    CIS_OP_SUBB = 8'b00000010,
    CIS_OP_SWAP = 8'b00000100,
    CIS_OP_XORF = 8'b00001000,
    CIS_OP_TSTZ = 8'b00010000,
    CIS_OP_XORL = 8'b00100000,
    CIS_OP_TRD = 8'b01000000,
    CIS_OP_TWR = 8'b10000000
  } cis_op_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cis_bus_req_t;

  typedef struct packed {
    logic rd;
    logic hold_we;
    logic [20:0] addr;
    logic [7:0] wdata;
  } cis_pm_req_t;
endpackage

/* File: rtl/cis_core.sv */
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cis_regs.svh"
// Overview of operation
// - subtract with borrow: file minus working minus inverted carry, update arithmetic flags
// - destination bit 0 writes working register, 1 writes the file register
// - bank bit 0 uses access bank, 1 uses bank select register
// - bank bit 0, extension on, operand up to 95: indexed literal offset
// - nibble swap of file register to destination, flags untouched
// - table read fetches program byte at 21-bit pointer into latch, two cycles
// - low bits: keep, post-increment, post-decrement, pre-increment pointer
// - table write copies latch to holding register, same pointer modes, two cycles
// - test file: zero discards fetched next instruction, runs no-op instead
// - skip over a two-word instruction takes three cycles in total
// - xor literal into working register, update negative and zero
// - xor working with file to destination, update negative and zero
module cis_core #(
  parameter int DMEM_DEPTH = 4096
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // instruction stream
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic next_two_word_i,
  output logic instr_ready_o,
  output logic flush_o,
  // program memory and holding registers
  output cis_pkg::cis_pm_req_t pm_o,
  input wire logic [7:0] pm_rdata_i,
  // register port
  input wire cis_pkg::cis_bus_req_t bus_i,
  output logic [31:0] bus_rdata_o
);
  logic [7:0] dmem [DMEM_DEPTH];
  logic [1:0] qph;
  cis_pkg::cis_state_t state;
  cis_pkg::cis_state_t next_state;
  cis_pkg::cis_op_t op;
  logic [15:0] ir;
  logic [1:0] cyc;
  logic [1:0] cyc_last;
  logic [7:0] working_register;
  logic [3:0] bank_select_reg;
  logic [4:0] status_flags;
  logic [20:0] table_pointer;
  logic [7:0] table_latch;
  logic [11:0] index_base;
  logic ext_enable;
  logic [11:0] data_addr_sel;
  logic [7:0] opnd;
  logic [7:0] res_q;
  logic [4:0] stat_q;
  logic [7:0] next_res;
  logic [4:0] next_stat;

  function automatic cis_pkg::cis_op_t decode(input logic [15:0] w);
    if (w[15:10] == `CIS_OP6_SUBB) decode = cis_pkg::CIS_OP_SUBB;
    else if (w[15:10] == `CIS_OP6_SWAP) decode = cis_pkg::CIS_OP_SWAP;
    else if (w[15:10] == `CIS_OP6_XORF) decode = cis_pkg::CIS_OP_XORF;
    else if (w[15:9] == `CIS_OP7_TSTZ) decode = cis_pkg::CIS_OP_TSTZ;
    else if (w[15:8] == `CIS_OP8_XORL) decode = cis_pkg::CIS_OP_XORL;
    else if (w[15:2] == `CIS_OP14_TRD) decode = cis_pkg::CIS_OP_TRD;
    else if (w[15:2] == `CIS_OP14_TWR) decode = cis_pkg::CIS_OP_TWR;
    else decode = cis_pkg::CIS_OP_NONE;
  endfunction

  // handshake and phase decode
  wire logic run = (state == cis_pkg::CIS_S_RUN);
  wire logic accept = instr_ready_o & instr_valid_i;
  wire logic in_q4 = run & (qph == `CIS_Q4);
  wire logic first_cyc = (cyc == 2'h0);
  wire logic last_cyc = (cyc == cyc_last);
  wire logic op_subb = (op == cis_pkg::CIS_OP_SUBB);
  wire logic op_swap = (op == cis_pkg::CIS_OP_SWAP);
  wire logic op_xorf = (op == cis_pkg::CIS_OP_XORF);
  wire logic op_tstz = (op == cis_pkg::CIS_OP_TSTZ);
  wire logic op_xorl = (op == cis_pkg::CIS_OP_XORL);
  wire logic op_trd = (op == cis_pkg::CIS_OP_TRD);
  wire logic op_twr = (op == cis_pkg::CIS_OP_TWR);
  wire logic [1:0] tbl_mode = ir[1:0];
  wire logic dest_file = ir[9];
  wire logic bank_bit = ir[8];
  wire logic [7:0] f_fld = ir[7:0];
  assign instr_ready_o = (state == cis_pkg::CIS_S_IDLE) & (qph == `CIS_Q1);

  // operand address
  wire logic use_idx = ext_enable & ~bank_bit & (f_fld <= `CIS_IDX_MAX);
  wire logic [11:0] idx_addr = 12'(index_base + {4'h0, f_fld});
  wire logic [11:0] acc_addr = (f_fld < `CIS_ACC_SPLIT) ? {4'h0, f_fld} : {`CIS_ACC_HI_BANK, f_fld};
  wire logic [11:0] ea = use_idx ? idx_addr : bank_bit ? {bank_select_reg, f_fld} : acc_addr;

  // arithmetic; carry set means no borrow
  wire logic cin = status_flags[`CIS_ST_C];
  wire logic [8:0] sub_full = {1'b0, opnd} + {1'b0, ~working_register} + {8'h00, cin};
  wire logic [4:0] sub_half = {1'b0, opnd[3:0]} + {1'b0, ~working_register[3:0]} + {4'h0, cin};
  wire logic sub_ov = (opnd[7] != working_register[7]) & (sub_full[7] != opnd[7]);
  wire logic [7:0] xor_src = op_xorl ? f_fld : opnd;

  // writeback decode
  wire logic wb_op = op_subb | op_swap | op_xorf | op_xorl;
  wire logic wb = in_q4 & first_cyc & wb_op;
  wire logic wb_work = wb & (op_xorl | ~dest_file);
  wire logic core_dwe = wb & ~op_xorl & dest_file;
  wire logic wb_flags = wb & ~op_swap;
  wire logic skip_now = run & first_cyc & (qph == `CIS_Q3) & op_tstz & (opnd == 8'h00);
  assign flush_o = in_q4 & first_cyc & op_tstz & (cyc_last != 2'h0);

  // table pointer update
  wire logic tbl_op = op_trd | op_twr;
  wire logic ptr_pre = in_q4 & first_cyc & tbl_op & (tbl_mode == `CIS_TBL_PREINC);
  wire logic ptr_post = in_q4 & ~first_cyc & tbl_op;
  wire logic ptr_inc = ptr_pre | (ptr_post & (tbl_mode == `CIS_TBL_POSTINC));
  wire logic ptr_dec = ptr_post & (tbl_mode == `CIS_TBL_POSTDEC);
  wire logic tbl_issue = run & ~first_cyc & (qph == `CIS_Q1);
  wire logic lat_load = run & ~first_cyc & (qph == `CIS_Q3) & op_trd;

  // register port decode
  wire logic bw = bus_i.we;
  wire logic [7:0] ba = bus_i.addr;
  wire logic bw_work = bw & (ba == `CIS_OFS_WORK);
  wire logic bw_bank = bw & (ba == `CIS_OFS_BANK);
  wire logic bw_stat = bw & (ba == `CIS_OFS_STATUS);
  wire logic bw_ptr = bw & (ba == `CIS_OFS_TPTR);
  wire logic bw_lat = bw & (ba == `CIS_OFS_TBLLAT);
  wire logic bw_ctrl = bw & (ba == `CIS_OFS_CTRL);
  wire logic bw_idx = bw & (ba == `CIS_OFS_IDXBASE);
  wire logic bw_dadr = bw & (ba == `CIS_OFS_DADDR);
  wire logic bw_ddat = bw & (ba == `CIS_OFS_DDATA);
  logic [31:0] rd_mux;

  always_comb begin
    unique case (ba)
      `CIS_OFS_WORK: rd_mux = {24'h000000, working_register};
      `CIS_OFS_BANK: rd_mux = {28'h0000000, bank_select_reg};
      `CIS_OFS_STATUS: rd_mux = {27'h0000000, status_flags};
      `CIS_OFS_TPTR: rd_mux = {11'h000, table_pointer};
      `CIS_OFS_TBLLAT: rd_mux = {24'h000000, table_latch};
      `CIS_OFS_CTRL: rd_mux = {30'h00000000, run, ext_enable};
      `CIS_OFS_IDXBASE: rd_mux = {20'h00000, index_base};
      `CIS_OFS_DADDR: rd_mux = {20'h00000, data_addr_sel};
      `CIS_OFS_DDATA: rd_mux = {24'h000000, dmem[data_addr_sel]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // result and flags for the process phase
  always_comb begin
    next_res = opnd;
    next_stat = status_flags;
    unique case (op)
      cis_pkg::CIS_OP_SUBB: begin
        next_res = sub_full[7:0];
        next_stat[`CIS_ST_C] = sub_full[8];
        next_stat[`CIS_ST_DC] = sub_half[4];
        next_stat[`CIS_ST_OV] = sub_ov;
      end
      cis_pkg::CIS_OP_SWAP: next_res = {opnd[3:0], opnd[7:4]};
      cis_pkg::CIS_OP_XORF, cis_pkg::CIS_OP_XORL: next_res = working_register ^ xor_src;
      default: next_res = opnd;
    endcase
    next_stat[`CIS_ST_Z] = (next_res == 8'h00);
    next_stat[`CIS_ST_N] = next_res[7];
  end

  always_comb begin
    next_state = state;
    unique case (state)
      cis_pkg::CIS_S_IDLE: if (accept) next_state = cis_pkg::CIS_S_RUN;
      cis_pkg::CIS_S_RUN: if (in_q4 & last_cyc) next_state = cis_pkg::CIS_S_IDLE;
      default: next_state = cis_pkg::CIS_S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qph <= `CIS_Q1;
      state <= cis_pkg::CIS_S_IDLE;
    end else begin
      qph <= qph + 2'h1;
      state <= next_state;
    end
  end

  // instruction latch and cycle count
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ir <= `CIS_RST_IR;
      op <= cis_pkg::CIS_OP_NONE;
      cyc <= 2'h0;
      cyc_last <= 2'h0;
    end else if (accept) begin
      ir <= instr_i;
      op <= decode(instr_i);
      cyc <= 2'h0;
      cyc_last <= (decode(instr_i) inside {cis_pkg::CIS_OP_TRD, cis_pkg::CIS_OP_TWR}) ? `CIS_XTRA_TBL : 2'h0;
    end else begin
      if (skip_now) cyc_last <= next_two_word_i ? `CIS_XTRA_SKIP2 : `CIS_XTRA_SKIP1;
      if (in_q4 & ~last_cyc) cyc <= cyc + 2'h1;
    end
  end

  // datapath pipeline through the quarter phases
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      opnd <= 8'h00;
      res_q <= 8'h00;
      stat_q <= `CIS_RST_STATUS;
    end else begin
      if (run & first_cyc & (qph == `CIS_Q2)) opnd <= dmem[ea];
      if (run & first_cyc & (qph == `CIS_Q3)) res_q <= next_res;
      if (run & first_cyc & (qph == `CIS_Q3)) stat_q <= next_stat;
    end
  end

  // core writeback wins over a register-port write in the same cycle
  always_ff @(posedge mclk_i) begin
    if (core_dwe) dmem[ea] <= res_q;
    else if (bw_ddat) dmem[data_addr_sel] <= bus_i.wdata[7:0];
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      working_register <= `CIS_RST_WORK;
      status_flags <= `CIS_RST_STATUS;
    end else begin
      if (wb_work) working_register <= res_q;
      else if (bw_work) working_register <= bus_i.wdata[7:0];
      if (wb_flags) status_flags <= stat_q;
      else if (bw_stat) status_flags <= bus_i.wdata[4:0];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      table_pointer <= `CIS_RST_TPTR;
      table_latch <= `CIS_RST_TBLLAT;
    end else begin
      if (ptr_inc) table_pointer <= table_pointer + 21'h000001;
      else if (ptr_dec) table_pointer <= table_pointer - 21'h000001;
      else if (bw_ptr) table_pointer <= bus_i.wdata[20:0];
      if (lat_load) table_latch <= pm_rdata_i;
      else if (bw_lat) table_latch <= bus_i.wdata[7:0];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bank_select_reg <= `CIS_RST_BANK;
      ext_enable <= 1'b0;
      index_base <= `CIS_RST_IDXBASE;
      data_addr_sel <= 12'h000;
    end else begin
      if (bw_bank) bank_select_reg <= bus_i.wdata[3:0];
      if (bw_ctrl) ext_enable <= bus_i.wdata[`CIS_CTRL_EXT];
      if (bw_idx) index_base <= bus_i.wdata[11:0];
      if (bw_dadr) data_addr_sel <= bus_i.wdata[11:0];
    end
  end

  // program memory strobes stand in the second quarter of the second cycle
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pm_o <= '0;
      bus_rdata_o <= 32'h00000000;
    end else begin
      pm_o.rd <= tbl_issue & op_trd;
      pm_o.hold_we <= tbl_issue & op_twr;
      pm_o.addr <= table_pointer;
      pm_o.wdata <= table_latch;
      bus_rdata_o <= bus_i.re ? rd_mux : 32'h00000000;
    end
  end

  // checks
  default clocking chk_clk @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  wire logic [7:0] chk_sub = 8'(opnd - working_register - {7'h00, ~cin});

  // ready stays low for the rest of the instruction, then returns in a Q1 clock
  sequence s_two_cyc;
    !instr_ready_o [*7] ##1 instr_ready_o;
  endsequence
  sequence s_skip_one;
    !instr_ready_o [*4] ##1 instr_ready_o;
  endsequence
  sequence s_skip_two;
    !instr_ready_o [*8] ##1 instr_ready_o;
  endsequence

  chk_sub_borrow_value: assert property (
    (wb & op_subb & ~dest_file) |=> working_register == $past(chk_sub))
    else $error("borrow subtract result wrong");
  chk_dest_select: assert property (
    (in_q4 & first_cyc & (op_subb | op_swap | op_xorf)) |-> (core_dwe == dest_file) && (wb_work == !dest_file))
    else $error("destination select wrong");
  // operand fetch checked against the memory itself, not against the address mux
  wire logic chk_rd_phase = run & first_cyc & (qph == `CIS_Q2) & (op_subb | op_swap | op_xorf | op_tstz);
  chk_bank_address: assert property (
    (chk_rd_phase & bank_bit)
      |=> opnd == $past(dmem[{bank_select_reg, f_fld}]))
    else $error("banked operand wrong");
  chk_index_address: assert property (
    (chk_rd_phase & ext_enable & ~bank_bit & (f_fld <= 8'h5f))
      |=> opnd == $past(dmem[12'(index_base + {4'h0, f_fld})]))
    else $error("indexed operand wrong");
  chk_swap_flags_kept: assert property (
    (wb & op_swap & ~bw_stat) |=> $stable(status_flags) && (res_q == {opnd[3:0], opnd[7:4]}))
    else $error("swap changed flags or value");
  chk_table_two_cycles: assert property (
    (accept & (decode(instr_i) inside {cis_pkg::CIS_OP_TRD, cis_pkg::CIS_OP_TWR})) |=> s_two_cyc)
    else $error("table op not two cycles");
  chk_table_latch_load: assert property (
    (pm_o.rd & ~bw_lat) |=> ##1 table_latch == $past(pm_rdata_i))
    else $error("table latch not loaded");
  chk_ptr_postinc: assert property (
    (accept & (decode(instr_i) == cis_pkg::CIS_OP_TRD) & (instr_i[1:0] == 2'h1) & ~bw_ptr)
      |-> ##8 table_pointer == 21'($past(table_pointer, 8) + 21'h000001))
    else $error("post increment wrong");
  // program strobes stand five clocks after the accept clock
  chk_ptr_preinc: assert property (
    (accept & (decode(instr_i) == cis_pkg::CIS_OP_TRD) & (instr_i[1:0] == 2'h3) & ~bw_ptr)
      |-> ##5 pm_o.rd && (pm_o.addr == 21'($past(table_pointer, 5) + 21'h000001)))
    else $error("pre increment address wrong");
  chk_hold_write_data: assert property (
    (accept & (decode(instr_i) == cis_pkg::CIS_OP_TWR) & ~bw_lat)
      |-> ##5 pm_o.hold_we && (pm_o.wdata == $past(table_latch, 5)))
    else $error("holding register data wrong");
  chk_skip_one_word: assert property (
    (flush_o & (cyc_last == 2'h1)) |=> s_skip_one)
    else $error("skip length wrong");
  chk_skip_two_word: assert property (
    (flush_o & (cyc_last == 2'h2)) |=> s_skip_two)
    else $error("two-word skip length wrong");
  chk_xor_literal: assert property (
    (wb & op_xorl) |=> working_register == $past(working_register ^ f_fld)
      && status_flags[`CIS_ST_Z] == (working_register == 8'h00))
    else $error("xor literal wrong");
  chk_xor_file_flags: assert property (
    (wb & op_xorf) |=> status_flags[`CIS_ST_N] == $past(res_q[7]))
    else $error("xor file flags wrong");
endmodule // cis_core
`default_nettype wire

/* File: verif/cis_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cis_regs.svh"
module cis_core_test;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic instr_valid_i = 1'b0;
  logic next_two_word_i = 1'b0;
  logic [7:0] pm_rdata_i = 8'h00;
  cis_pkg::cis_bus_req_t bus_i = '0;
  logic instr_ready_o;
  logic flush_o;
  cis_pkg::cis_pm_req_t pm_o;
  logic [31:0] bus_rdata_o;
  int n_fail = 0;
  int checks = 0;
  int cyc;
  logic saw_flush, saw_rd, saw_we;
  logic [20:0] pm_addr;
  logic [7:0] pm_wd;
  logic [7:0] pm_byte = 8'h00;
  logic [31:0] rd;

  always #2.5 mclk_i = ~mclk_i;

  // program byte only valid the clock after a read pulse
  always @(posedge mclk_i) pm_rdata_i <= (pm_o.rd === 1'b1) ? pm_byte : ~pm_byte;

  cis_core dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .next_two_word_i(next_two_word_i), .instr_ready_o(instr_ready_o), .flush_o(flush_o),
    .pm_o(pm_o), .pm_rdata_i(pm_rdata_i), .bus_i(bus_i), .bus_rdata_o(bus_rdata_o)
  );

  task automatic wrap_up;
    $display("mismatches %0d, comparisons %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // extra edge keeps two strobes from landing in one time step
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    bus_i <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    bus_i <= '0;
    @(posedge mclk_i);
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    bus_i <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
    @(posedge mclk_i);
    bus_i <= '0;
    @(negedge mclk_i);
    d = bus_rdata_o;
    @(posedge mclk_i);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    reg_rd(a, rd);
    check(rd & mask, exp);
  endtask

  task automatic put_f(input logic [11:0] fa, input logic [7:0] v);
    reg_wr(`CIS_OFS_DADDR, {20'h0, fa});
    reg_wr(`CIS_OFS_DDATA, {24'h0, v});
  endtask

  task automatic chk_f(input logic [11:0] fa, input logic [7:0] exp);
    reg_wr(`CIS_OFS_DADDR, {20'h0, fa});
    chk_reg(`CIS_OFS_DDATA, 32'hff, {24'h0, exp});
  endtask

  // result lands in the working register or back in the file
  task automatic res(input logic d, input logic [7:0] r, input logic [7:0] w0, input logic [7:0] f0,
                     input logic [11:0] fa);
    chk_reg(`CIS_OFS_WORK, 32'hff, {24'h0, d ? w0 : r});
    chk_f(fa, d ? r : f0);
  endtask

  task automatic to_fail;
    n_fail++;
    wrap_up;
  endtask

  // offer one word, then count clocks until ready returns
  task automatic run(input logic [15:0] w);
    int n;
    n = 0;
    instr_i <= w;
    instr_valid_i <= 1'b1;
    saw_flush = 1'b0;
    saw_rd = 1'b0;
    saw_we = 1'b0;
    @(negedge mclk_i);
    while (instr_ready_o !== 1'b1) begin
      n++;
      if (n > 40) to_fail;
      @(negedge mclk_i);
    end
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
      if (flush_o === 1'b1) saw_flush = 1'b1;
      if (pm_o.rd === 1'b1) begin
        saw_rd = 1'b1;
        pm_addr = pm_o.addr;
      end
      if (pm_o.hold_we === 1'b1) begin
        saw_we = 1'b1;
        pm_addr = pm_o.addr;
        pm_wd = pm_o.wdata;
      end
    end while (instr_ready_o !== 1'b1 && n < 40);
    if (n >= 40) to_fail;
    cyc = n;
    @(posedge mclk_i);
  endtask

  logic [7:0] sf[3] = '{8'h19, 8'h1b, 8'h03};
  logic [7:0] sw[3] = '{8'h0d, 8'h1a, 8'h0e};
  logic sc[3] = '{1'b1, 1'b0, 1'b1};
  logic sd[3] = '{1'b1, 1'b0, 1'b1};
  logic [7:0] sr[3] = '{8'h0c, 8'h00, 8'hf5};
  logic [31:0] sst[3] = '{32'h01, 32'h07, 32'h10};
  logic [7:0] tv[3] = '{8'h01, 8'h00, 8'h00};
  logic tw[3] = '{1'b0, 1'b0, 1'b1};
  int tc[3] = '{4, 8, 12};
  logic [20:0] tp[4] = '{21'h00a356, 21'h00a357, 21'h00a355, 21'h00a357};
  logic [7:0] offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40};

  initial begin
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    foreach (offs[i]) chk_reg(offs[i], 32'hffffffff, 32'h0);
    reg_wr(8'h40, 32'h5a);
    chk_reg(8'h40, 32'hffffffff, 32'h0);
    for (int i = 0; i < 3; i++) begin
      put_f(12'h020, sf[i]);
      reg_wr(`CIS_OFS_WORK, {24'h0, sw[i]});
      reg_wr(`CIS_OFS_STATUS, {31'h0, sc[i]});
      run({6'h16, sd[i], 1'b0, 8'h20});
      check(cyc, 4);
      chk_reg(`CIS_OFS_STATUS, 32'h1f, sst[i]);
      res(sd[i], sr[i], sw[i], sf[i], 12'h020);
    end
    reg_wr(`CIS_OFS_BANK, 32'h3);
    put_f(12'h310, 8'h53);
    reg_wr(`CIS_OFS_STATUS, 32'h1f);
    reg_wr(`CIS_OFS_WORK, 32'h77);
    run({6'h0e, 1'b1, 1'b1, 8'h10});
    res(1'b1, 8'h35, 8'h77, 8'h53, 12'h310);
    chk_reg(`CIS_OFS_STATUS, 32'h1f, 32'h1f);
    put_f(12'hf90, 8'hc4);
    run({6'h0e, 1'b0, 1'b0, 8'h90});
    res(1'b0, 8'h4c, 8'h00, 8'hc4, 12'hf90);
    reg_wr(`CIS_OFS_CTRL, 32'h1);
    reg_wr(`CIS_OFS_IDXBASE, 32'h200);
    put_f(12'h25f, 8'h1e);
    run({6'h0e, 1'b1, 1'b0, 8'h5f});
    chk_f(12'h25f, 8'he1);
    put_f(12'h060, 8'h2d);
    run({6'h0e, 1'b1, 1'b0, 8'h60});
    chk_f(12'h060, 8'hd2);
    reg_wr(`CIS_OFS_CTRL, 32'h0);
    reg_wr(`CIS_OFS_WORK, 32'hb5);
    run({8'h0a, 8'haf});
    chk_reg(`CIS_OFS_WORK, 32'hff, 32'h1a);
    chk_reg(`CIS_OFS_STATUS, 32'h14, 32'h00);
    run({8'h0a, 8'h1a});
    chk_reg(`CIS_OFS_STATUS, 32'h14, 32'h04);
    run({8'h0a, 8'h80});
    chk_reg(`CIS_OFS_STATUS, 32'h14, 32'h10);
    put_f(12'h020, 8'haf);
    reg_wr(`CIS_OFS_WORK, 32'hb5);
    run({6'h06, 1'b1, 1'b0, 8'h20});
    res(1'b1, 8'h1a, 8'hb5, 8'haf, 12'h020);
    run({6'h06, 1'b0, 1'b0, 8'h20});
    res(1'b0, 8'haf, 8'h00, 8'h1a, 12'h020);
    chk_reg(`CIS_OFS_STATUS, 32'h14, 32'h10);
    for (int i = 0; i < 3; i++) begin
      put_f(12'h020, tv[i]);
      next_two_word_i <= tw[i];
      run({7'h33, 1'b0, 8'h20});
      check(cyc, tc[i]);
      check({31'h0, saw_flush}, {31'h0, tv[i] == 8'h00});
    end
    next_two_word_i <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      reg_wr(`CIS_OFS_TPTR, 32'h00a356);
      reg_wr(`CIS_OFS_TBLLAT, 32'h55 + k);
      pm_byte = 8'h30 + k[7:0];
      run({14'h0002 + k[2], k[1:0]});
      check(cyc, 8);
      check({11'h0, pm_addr}, (k[1:0] == 2'h3) ? 32'h00a357 : 32'h00a356);
      chk_reg(`CIS_OFS_TPTR, 32'h1fffff, {11'h0, tp[k[1:0]]});
      if (k[2]) begin
        check({31'h0, saw_we}, 32'h1);
        check({24'h0, pm_wd}, 32'h55 + k);
      end else begin
        check({31'h0, saw_rd}, 32'h1);
        chk_reg(`CIS_OFS_TBLLAT, 32'hff, 32'h30 + k);
      end
    end
    wrap_up;
  end
endmodule // cis_core_test
`default_nettype wire
